// File: core/psw_defines.svh
// Purpose: shared offsets, field positions, encodings and timing counts
// Assumes: 32-bit register words on an 8-bit byte address
// Notes: times are in ns, counts are derived from the clock period
`ifndef PSW_DEFINES_SVH
`define PSW_DEFINES_SVH

`define PSW_ADDR_W 8
`define PSW_DATA_W 32

`define PSW_OFF_IRQ_STATUS 8'h58
`define PSW_OFF_IRQ_ENABLE 8'h5c
`define PSW_OFF_BYTE_TEST 8'h64
`define PSW_OFF_PMC 8'h84
`define PSW_OFF_PHY_CTRL 8'h90
`define PSW_OFF_PHY_MODE 8'h94
`define PSW_OFF_PHY_IRQ_FLAG 8'h98
`define PSW_OFF_PHY_IRQ_MASK 8'h9c

// power management control register fields
`define PSW_PMC_READY 0
`define PSW_PMC_PIN_EN 1
`define PSW_PMC_PULSE_SEL 3
`define PSW_PMC_WS_LO 4
`define PSW_PMC_WFE 8
`define PSW_PMC_EDE 9
`define PSW_PMC_SEL_LO 12
// irq status / enable fields
`define PSW_IRQ_WAKE 0
`define PSW_IRQ_PHY 1
// phy fields
`define PSW_PHY_PD_BIT 11
`define PSW_PHY_EDPD_BIT 13
`define PSW_PHY_ENERGY_IRQ 1

// power state select encodings
`define PSW_SEL_D0 2'h0
`define PSW_SEL_D1 2'h1
`define PSW_SEL_D2 2'h2
// wake status encodings
`define PSW_WS_FRAME 2'h2
`define PSW_WS_ENERGY 2'h1

// arbitrary value, read back from the byte test register
`define PSW_BYTE_TEST_VAL 32'h5a3c_c3a5

`define PSW_CLK_NS 10
`define PSW_READY_MAX_NS 2000000
`define PSW_READY_CYCLES (`PSW_READY_MAX_NS / `PSW_CLK_NS)
`define PSW_PULSE_NS 50000000
`define PSW_PULSE_CYCLES (`PSW_PULSE_NS / `PSW_CLK_NS)

`endif

// File: core/psw_pkg.sv
// Purpose: state types shared by both ends
// Assumes: nothing
// Notes: encodings follow a Gray path
package psw_pkg;
	typedef enum logic [1:0] {
		psw_d0 = 2'b00,
		psw_d1 = 2'b01,
		psw_waking = 2'b11,
		psw_d2 = 2'b10
	} psw_dev_state_type;

	typedef enum logic [1:0] {
		psw_h_idle = 2'b00,
		psw_h_pre = 2'b01,
		psw_h_acc = 2'b11,
		psw_h_cap = 2'b10
	} psw_host_state_type;
endpackage

// File: core/psw_bus_if.sv
// Purpose: sram-like register bus plus wake event line between both ends
// Assumes: one access per cs cycle, read data valid one cycle later
// Notes: no clocking block
`timescale 1ns/1ns
`include "psw_defines.svh"
interface psw_bus_if;
	logic cs;
	logic rd;
	logic wr;
	logic [`PSW_ADDR_W-1:0] addr;
	logic [`PSW_DATA_W-1:0] wdata;
	logic [`PSW_DATA_W-1:0] rdata;
	logic wake_pin;

	modport device (
		input cs,
		input rd,
		input wr,
		input addr,
		input wdata,
		output rdata,
		output wake_pin
	);
	modport host (
		output cs,
		output rd,
		output wr,
		output addr,
		output wdata,
		input rdata,
		input wake_pin
	);
endinterface

// File: core/psw_device.sv
// Purpose: power state and wake controller of the network device
// Assumes: host keeps to the access limits while ready is clear
// Notes: clock gating is exported as enables; this logic itself keeps running
//
// Overview of operation
// - D0 plus D1, D2; sleeping reads only control
// - ready clears on sleep entry until D0
// - host reads control, writes byte test only
// - writes ignored until one read after wake
// - byte test write in sleep returns D0
// - writing 01 enters D1, partial clock gating
// - D1 frame detect sets status 10b, pin
// - host programs filter and enables before D1
// - host sets energy powerdown before writing 10b
// - D2 stops mac, bus, internal clocks
// - D2 carrier sets status 01b, pin
// - carrier present at D2 entry detects immediately
// - host clears energy powerdown only after ready
// - host clears wake status only when ready
// - wake irq bit sticky while wake signal active
// - wake irq set regardless of pin enable
// - pulse select: 50ms pulse, else static pin
// - pin drops on status, detect or pin enable clear
// - wake status field readable
// - phy powered down while 0.11 high
// - 17.13 powers phy down without line energy
// - line energy wakes phy, sets phy irq flag
// - ready set within 2ms of wake write
`timescale 1ns/1ns
`include "psw_defines.svh"
module psw_device #(
	parameter int READY_CYCLES = `PSW_READY_CYCLES,
	parameter int PULSE_CYCLES = `PSW_PULSE_CYCLES
) (
	input wire logic clk_sys,
	input wire logic resetn,
	psw_bus_if.device bus,
	input wire logic wake_frame_seen,
	input wire logic line_energy_raw,
	output logic host_irq,
	output logic host_clk_en,
	output logic mac_pm_clk_en,
	output logic int_clk_en,
	output logic phy_power_down,
	output logic phy_soft_reset,
	output logic phy_active,
	output logic [1:0] power_state
);
	localparam int RW = $clog2(READY_CYCLES + 1);
	localparam int PW = $clog2(PULSE_CYCLES + 1);
	localparam logic [RW-1:0] READY_LAST = RW'(READY_CYCLES - 1);
	localparam logic [PW-1:0] PULSE_LAST = PW'(PULSE_CYCLES - 1);

	if (READY_CYCLES < 1 || PULSE_CYCLES < 1) begin : g_bad_param
		$error("psw_device: cycle counts must be at least one");
	end

	psw_pkg::psw_dev_state_type state, next_state;
	logic [RW-1:0] ready_cnt;
	logic [PW-1:0] pulse_cnt;
	logic armed;
	logic wake_pin_en, pulse_sel, frame_en, energy_en;
	logic [1:0] wake_status;
	logic [1:0] irq_status, irq_enable;
	logic phy_pd, phy_edpd, phy_irq_flag, phy_irq_mask;
	logic en_s1, en_s2, en_s3, energy;
	logic energy_d, wake_sig_d, pin_on;
	logic [`PSW_DATA_W-1:0] rdata;

	// bus decode
	wire rd_cyc = bus.cs & bus.rd;
	wire wr_cyc = bus.cs & bus.wr;
	wire hit_pmc = bus.addr == `PSW_OFF_PMC;
	wire hit_bt = bus.addr == `PSW_OFF_BYTE_TEST;
	wire hit_ist = bus.addr == `PSW_OFF_IRQ_STATUS;
	wire hit_ien = bus.addr == `PSW_OFF_IRQ_ENABLE;
	wire hit_pctl = bus.addr == `PSW_OFF_PHY_CTRL;
	wire hit_pmode = bus.addr == `PSW_OFF_PHY_MODE;
	wire hit_pflag = bus.addr == `PSW_OFF_PHY_IRQ_FLAG;
	wire hit_pmask = bus.addr == `PSW_OFF_PHY_IRQ_MASK;
	wire in_d0 = state == psw_pkg::psw_d0;
	wire in_d1 = state == psw_pkg::psw_d1;
	wire in_d2 = state == psw_pkg::psw_d2;
	wire ready = in_d0;
	wire wake_wr = wr_cyc & hit_bt & (in_d1 | in_d2);
	wire wr_ok = wr_cyc & armed & in_d0;
	wire [1:0] sel_wr = bus.wdata[`PSW_PMC_SEL_LO +: 2];
	wire pmc_wr = wr_ok & hit_pmc;

	wire [1:0] sel_now = in_d1 ? `PSW_SEL_D1 :
		(in_d2 ? `PSW_SEL_D2 : `PSW_SEL_D0);

	wire set_frame = in_d1 & wake_frame_seen;
	// level check catches carrier already present
	wire set_energy = in_d2 & energy;
	wire [1:0] ws_clr = pmc_wr ? bus.wdata[`PSW_PMC_WS_LO +: 2] : 2'h0;
	wire [1:0] next_ws = (wake_status & ~ws_clr) | {set_frame, set_energy};

	wire wake_sig = (wake_status[1] & frame_en) | (wake_status[0] & energy_en);
	wire sig_rise = wake_sig & ~wake_sig_d;
	wire [1:0] ist_w1c = (wr_ok & hit_ist) ? bus.wdata[1:0] : 2'h0;
	// clear only once signal is gone, set wins
	wire next_ist_wake = wake_sig | (irq_status[0] & ~ist_w1c[0]);
	wire ist_phy = phy_irq_flag & phy_irq_mask;

	wire pin_drop = ~wake_sig | ~wake_pin_en;
	wire pulse_end = pulse_sel & pin_on & (pulse_cnt == PULSE_LAST);

	wire energy_rise = energy & ~energy_d & phy_edpd;
	wire pflag_clr = wr_ok & hit_pflag & bus.wdata[`PSW_PHY_ENERGY_IRQ];
	wire pd_clear = wr_ok & hit_pctl & phy_pd & ~bus.wdata[`PSW_PHY_PD_BIT];

	wire [`PSW_DATA_W-1:0] pmc_rd = {
		{(`PSW_DATA_W - 14){1'b0}}, sel_now, 2'h0, energy_en, frame_en,
		2'h0, wake_status, pulse_sel, 1'b0, wake_pin_en, ready};

	// only the control register answers while asleep
	wire [`PSW_DATA_W-1:0] next_rdata =
		hit_pmc ? pmc_rd :
		~in_d0 ? '0 :
		hit_bt ? `PSW_BYTE_TEST_VAL :
		hit_ist ? {30'h0, ist_phy, irq_status[0]} :
		hit_ien ? {30'h0, irq_enable} :
		hit_pctl ? 32'(phy_pd) << `PSW_PHY_PD_BIT :
		hit_pmode ? 32'(phy_edpd) << `PSW_PHY_EDPD_BIT :
		hit_pflag ? 32'(phy_irq_flag) << `PSW_PHY_ENERGY_IRQ :
		hit_pmask ? 32'(phy_irq_mask) << `PSW_PHY_ENERGY_IRQ : '0;

	always_comb begin
		next_state = state;
		case (state)
			psw_pkg::psw_d0: begin
				if (pmc_wr && sel_wr == `PSW_SEL_D1) begin
					next_state = psw_pkg::psw_d1;
				end else if (pmc_wr && sel_wr == `PSW_SEL_D2) begin
					next_state = psw_pkg::psw_d2;
				end
			end
			psw_pkg::psw_d1, psw_pkg::psw_d2: begin
				if (wake_wr) begin
					next_state = psw_pkg::psw_waking;
				end
			end
			psw_pkg::psw_waking: begin
				if (ready_cnt == READY_LAST) begin
					next_state = psw_pkg::psw_d0;
				end
			end
			default: next_state = psw_pkg::psw_d0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state <= psw_pkg::psw_d0;
			ready_cnt <= '0;
		end else begin
			state <= next_state;
			ready_cnt <= (state == psw_pkg::psw_waking) ? ready_cnt + 1'b1 : '0;
		end
	end

	// arm on any read, disarm on wake
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			armed <= 1'b0;
		end else if (rd_cyc) begin
			armed <= 1'b1;
		end else if (wake_wr) begin
			armed <= 1'b0;
		end
	end

	// line energy pin synchroniser, accepted when stages two and three agree
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			en_s1 <= 1'b0;
			en_s2 <= 1'b0;
			en_s3 <= 1'b0;
			energy <= 1'b0;
		end else begin
			en_s1 <= line_energy_raw;
			en_s2 <= en_s1;
			en_s3 <= en_s2;
			energy <= (en_s2 == en_s3) ? en_s3 : energy;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wake_pin_en <= 1'b0;
			pulse_sel <= 1'b0;
			frame_en <= 1'b0;
			energy_en <= 1'b0;
			irq_enable <= 2'h0;
			phy_pd <= 1'b0;
			phy_edpd <= 1'b0;
			phy_irq_mask <= 1'b0;
		end else begin
			if (pmc_wr) begin
				wake_pin_en <= bus.wdata[`PSW_PMC_PIN_EN];
				pulse_sel <= bus.wdata[`PSW_PMC_PULSE_SEL];
				frame_en <= bus.wdata[`PSW_PMC_WFE];
				energy_en <= bus.wdata[`PSW_PMC_EDE];
			end
			if (wr_ok && hit_ien) begin
				irq_enable <= bus.wdata[1:0];
			end
			if (wr_ok && hit_pctl) begin
				phy_pd <= bus.wdata[`PSW_PHY_PD_BIT];
			end
			if (wr_ok && hit_pmode) begin
				phy_edpd <= bus.wdata[`PSW_PHY_EDPD_BIT];
			end
			if (wr_ok && hit_pmask) begin
				phy_irq_mask <= bus.wdata[`PSW_PHY_ENERGY_IRQ];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wake_status <= 2'h0;
			irq_status <= 2'h0;
			phy_irq_flag <= 1'b0;
			energy_d <= 1'b0;
			wake_sig_d <= 1'b0;
		end else begin
			wake_status <= next_ws;
			irq_status <= {ist_phy, next_ist_wake};
			phy_irq_flag <= energy_rise | (phy_irq_flag & ~pflag_clr);
			energy_d <= energy;
			wake_sig_d <= wake_sig;
		end
	end

	// release wins over a running pulse
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pin_on <= 1'b0;
			pulse_cnt <= '0;
		end else begin
			if (pin_drop || pulse_end) begin
				pin_on <= 1'b0;
			end else if (sig_rise) begin
				pin_on <= 1'b1;
			end
			pulse_cnt <= (pin_on && !sig_rise) ? pulse_cnt + 1'b1 : '0;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdata <= '0;
			host_irq <= 1'b0;
			host_clk_en <= 1'b1;
			mac_pm_clk_en <= 1'b1;
			int_clk_en <= 1'b1;
			phy_power_down <= 1'b0;
			phy_soft_reset <= 1'b0;
			phy_active <= 1'b1;
			power_state <= `PSW_SEL_D0;
		end else begin
			rdata <= rd_cyc ? next_rdata : rdata;
			host_irq <= |(irq_status & irq_enable);
			// D1 keeps phy and mac power block clocked
			// D2 stops mac, host bus and internal clocks
			host_clk_en <= ~(in_d1 | in_d2);
			mac_pm_clk_en <= ~in_d2;
			int_clk_en <= ~in_d2;
			phy_power_down <= phy_pd;
			phy_soft_reset <= pd_clear;
			phy_active <= ~phy_pd & (~phy_edpd | energy);
			power_state <= sel_now;
		end
	end

	assign bus.rdata = rdata;
	assign bus.wake_pin = pin_on;
endmodule

// File: core/psw_host.sv
// Purpose: host end, turns user commands into bus accesses, with an arming read ahead of the first write
// Assumes: one command at a time, answered by a response pulse
// Notes: commands that break the sleep access limits are refused
`timescale 1ns/1ns
`include "psw_defines.svh"
module psw_host (
	input wire logic clk_sys,
	input wire logic resetn,
	psw_bus_if.host bus,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_write,
	input wire logic [`PSW_ADDR_W-1:0] cmd_addr,
	input wire logic [`PSW_DATA_W-1:0] cmd_wdata,
	output logic rsp_valid,
	output logic rsp_refused,
	output logic [`PSW_DATA_W-1:0] rsp_data,
	output logic wake_seen
);
	psw_pkg::psw_host_state_type state, next_state;
	logic h_wr;
	logic [`PSW_ADDR_W-1:0] h_addr;
	logic [`PSW_DATA_W-1:0] h_wdata;
	logic need_read, sleeping, from_d2, edpd_shadow;

	wire take = cmd_valid & cmd_ready;
	wire c_pmc = cmd_addr == `PSW_OFF_PMC;
	wire c_bt = cmd_addr == `PSW_OFF_BYTE_TEST;
	wire [1:0] c_sel = cmd_wdata[`PSW_PMC_SEL_LO +: 2];
	wire bad_sleep = sleeping & (cmd_write ? ~c_bt : ~c_pmc);
	wire bad_d2 = cmd_write & c_pmc & (c_sel == `PSW_SEL_D2) & ~edpd_shadow;
	// status clear only when fully awake
	wire bad_ws = cmd_write & c_pmc & (|cmd_wdata[`PSW_PMC_WS_LO +: 2])
		& from_d2 & edpd_shadow;
	wire refuse = bad_sleep | bad_d2 | bad_ws;
	wire h_pmc = h_addr == `PSW_OFF_PMC;
	wire h_sel_nz = |h_wdata[`PSW_PMC_SEL_LO +: 2];
	wire in_acc = state == psw_pkg::psw_h_acc;
	wire in_pre = state == psw_pkg::psw_h_pre;
	wire in_cap = state == psw_pkg::psw_h_cap;

	assign cmd_ready = state == psw_pkg::psw_h_idle;
	assign bus.cs = in_pre | in_acc;
	assign bus.rd = in_pre | (in_acc & ~h_wr);
	assign bus.wr = in_acc & h_wr;
	assign bus.addr = in_pre ? `PSW_OFF_PMC : h_addr;
	assign bus.wdata = h_wdata;
	assign wake_seen = bus.wake_pin;

	always_comb begin
		next_state = state;
		case (state)
			psw_pkg::psw_h_idle: begin
				if (take && !refuse) begin
					// a read goes ahead of the first write
					next_state = (cmd_write && need_read) ?
						psw_pkg::psw_h_pre : psw_pkg::psw_h_acc;
				end
			end
			psw_pkg::psw_h_pre: next_state = psw_pkg::psw_h_acc;
			psw_pkg::psw_h_acc: next_state = psw_pkg::psw_h_cap;
			psw_pkg::psw_h_cap: next_state = psw_pkg::psw_h_idle;
			default: next_state = psw_pkg::psw_h_idle;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state <= psw_pkg::psw_h_idle;
			h_wr <= 1'b0;
			h_addr <= '0;
			h_wdata <= '0;
		end else begin
			state <= next_state;
			if (take) begin
				h_wr <= cmd_write;
				h_addr <= cmd_addr;
				h_wdata <= cmd_wdata;
			end
		end
	end

	// shadow of device sleep progress
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			need_read <= 1'b1;
			sleeping <= 1'b0;
			from_d2 <= 1'b0;
			edpd_shadow <= 1'b0;
		end else begin
			if (bus.cs && bus.rd) begin
				need_read <= 1'b0;
			end else if (in_acc && h_wr && h_addr == `PSW_OFF_BYTE_TEST) begin
				need_read <= 1'b1;
			end
			if (in_acc && h_wr && h_pmc && h_sel_nz) begin
				sleeping <= 1'b1;
				from_d2 <= h_wdata[`PSW_PMC_SEL_LO + 1];
			end else if (in_cap && !h_wr && h_pmc
				&& bus.rdata[`PSW_PMC_READY]) begin
				sleeping <= 1'b0;
			end else if (in_acc && h_wr
				&& h_addr == `PSW_OFF_PHY_MODE
				&& !h_wdata[`PSW_PHY_EDPD_BIT]) begin
				from_d2 <= 1'b0;
			end
			if (in_acc && h_wr && h_addr == `PSW_OFF_PHY_MODE) begin
				edpd_shadow <= h_wdata[`PSW_PHY_EDPD_BIT];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rsp_valid <= 1'b0;
			rsp_refused <= 1'b0;
			rsp_data <= '0;
		end else begin
			rsp_valid <= in_cap | (take & refuse);
			rsp_refused <= take & refuse;
			rsp_data <= (in_cap && !h_wr) ? bus.rdata : '0;
		end
	end
endmodule

// File: verification/psw_properties.sv
// Purpose: bus-level checks between host and device ends
// Assumes: host end inserts the arming read itself
// Notes: sleep and wake progress are inferred from bus traffic
`timescale 1ns/1ns
`include "psw_defines.svh"
module psw_properties #(
	parameter int READY_CYCLES = 4,
	parameter int PULSE_CYCLES = 8
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic cs,
	input wire logic rd,
	input wire logic wr,
	input wire logic [`PSW_ADDR_W-1:0] addr,
	input wire logic [`PSW_DATA_W-1:0] wdata,
	input wire logic [`PSW_DATA_W-1:0] rdata,
	input wire logic wake_pin
);
	logic sleep_q, woke_q, rd84_q, armed_q, edpd_q, pulse_q;
	logic [1:0] sel_q;
	logic [7:0] wake_cnt, pin_cnt;
	wire wr_pmc = cs & wr & (addr == `PSW_OFF_PMC);
	wire rd_pmc = cs & rd & (addr == `PSW_OFF_PMC);
	wire wake_wr = cs & wr & (addr == `PSW_OFF_BYTE_TEST) & sleep_q;
	wire wr_mode = cs & wr & (addr == `PSW_OFF_PHY_MODE) & ~sleep_q;
	wire awake_seen = rd84_q & rdata[0] & woke_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			{sleep_q, woke_q, rd84_q, armed_q, edpd_q, pulse_q} <= 6'h00;
			sel_q <= 2'h0;
		end else begin
			rd84_q <= rd_pmc;
			armed_q <= (armed_q | (cs & rd)) & ~wake_wr;
			if (wr_mode)
				edpd_q <= wdata[`PSW_PHY_EDPD_BIT];
			if (wr_pmc & ~sleep_q) begin
				sel_q <= wdata[13:12];
				pulse_q <= wdata[`PSW_PMC_PULSE_SEL];
				sleep_q <= (wdata[13:12] != 2'h0);
			end
			if (wake_wr)
				woke_q <= 1'b1;
			if (awake_seen) begin
				sleep_q <= 1'b0;
				woke_q <= 1'b0;
			end
		end
	end

	// cycles since the wake write, and length of the current pin pulse
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wake_cnt <= 8'h00;
			pin_cnt <= 8'h00;
		end else begin
			if (wake_wr)
				wake_cnt <= 8'h01;
			else if (woke_q && wake_cnt != 8'hff)
				wake_cnt <= wake_cnt + 8'h01;
			if (!wake_pin)
				pin_cnt <= 8'h00;
			else if (pin_cnt != 8'hff)
				pin_cnt <= pin_cnt + 8'h01;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	chk_sleep_reads: assert property (
		cs && rd && sleep_q |-> addr == `PSW_OFF_PMC)
		else $error("read of a blocked address while asleep");
	chk_sleep_writes: assert property (
		cs && wr && sleep_q |-> addr == `PSW_OFF_BYTE_TEST)
		else $error("write other than wake write while asleep");
	chk_not_ready: assert property (
		rd_pmc && sleep_q && !woke_q |=> rdata[`PSW_PMC_READY] == 1'b0)
		else $error("ready read high while asleep");
	chk_sleep_sel: assert property (
		rd_pmc && sleep_q && !woke_q |=> rdata[13:12] == $past(sel_q))
		else $error("state select does not show sleep state");
	chk_ready_bound: assert property (
		rd_pmc && woke_q && wake_cnt >= READY_CYCLES + 2 |=> rdata[0])
		else $error("ready late after wake write");
	chk_wake_d0: assert property (
		awake_seen |-> rdata[13:12] == `PSW_SEL_D0)
		else $error("state select not back to D0 after wake");
	chk_write_armed: assert property (
		cs && wr && !wake_wr |-> armed_q)
		else $error("write issued before any read");
	chk_d2_edpd: assert property (
		wr_pmc && wdata[13:12] == `PSW_SEL_D2 |-> edpd_q)
		else $error("D2 requested without energy powerdown");
	chk_pulse_len: assert property (
		pulse_q && wake_pin |-> pin_cnt < PULSE_CYCLES)
		else $error("wake pulse too long");
	chk_pin_off: assert property (
		wr_pmc && !sleep_q && !wdata[`PSW_PMC_PIN_EN] |-> ##2 !wake_pin)
		else $error("wake pin stays on after enable clear");
	chk_edpd_clear: assert property (
		cs && wr && addr == `PSW_OFF_PHY_MODE
			&& !wdata[`PSW_PHY_EDPD_BIT] |-> !sleep_q)
		else $error("energy powerdown cleared before ready");

	cov_wake_write: cover property (wake_wr);
	cov_pin_rise: cover property ($rose(wake_pin));
	cov_d2_entry: cover property (wr_pmc && wdata[13:12] == `PSW_SEL_D2);
endmodule

// File: verification/tb_power_state_wake_control.sv
// Purpose: drives host commands and wake inputs, judges both ends
// Assumes: shortened ready and pulse counts
// Notes: inputs change on the falling edge
`timescale 1ns/1ns
`include "psw_defines.svh"
module tb_power_state_wake_control;
	localparam int RC = 4;
	localparam int PC = 8;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_write = 1'b0;
	logic [7:0] cmd_addr = 8'h00;
	logic [31:0] cmd_wdata = 32'h0;
	logic wake_frame_seen = 1'b0;
	logic line_energy_raw = 1'b0;
	logic cmd_ready, rsp_valid, rsp_refused, wake_seen, host_irq;
	logic host_clk_en, mac_pm_clk_en, int_clk_en, phy_power_down;
	logic phy_soft_reset, phy_active, refd;
	logic srst_seen = 1'b0;
	logic [1:0] power_state;
	logic [31:0] rsp_data, rdat, cnt;
	int errors = 0;
	int checks = 0;

	psw_bus_if u_psw_bus_if ();
	psw_device #(.READY_CYCLES(RC), .PULSE_CYCLES(PC)) u_psw_device (
		.clk_sys(clk_sys), .resetn(resetn), .bus(u_psw_bus_if),
		.wake_frame_seen(wake_frame_seen),
		.line_energy_raw(line_energy_raw), .host_irq(host_irq),
		.host_clk_en(host_clk_en), .mac_pm_clk_en(mac_pm_clk_en),
		.int_clk_en(int_clk_en), .phy_power_down(phy_power_down),
		.phy_soft_reset(phy_soft_reset), .phy_active(phy_active),
		.power_state(power_state));
	psw_host u_psw_host (
		.clk_sys(clk_sys), .resetn(resetn), .bus(u_psw_bus_if),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_write(cmd_write), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
		.rsp_refused(rsp_refused), .rsp_data(rsp_data),
		.wake_seen(wake_seen));
	psw_properties #(.READY_CYCLES(RC), .PULSE_CYCLES(PC)) u_psw_properties (
		.clk_sys(clk_sys), .resetn(resetn), .cs(u_psw_bus_if.cs),
		.rd(u_psw_bus_if.rd), .wr(u_psw_bus_if.wr),
		.addr(u_psw_bus_if.addr), .wdata(u_psw_bus_if.wdata),
		.rdata(u_psw_bus_if.rdata), .wake_pin(u_psw_bus_if.wake_pin));

	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
		if (phy_soft_reset === 1'b1)
			srst_seen <= 1'b1;

	task close_out;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task cyc(input int k);
		repeat (k) @(negedge clk_sys);
	endtask

	task cmd(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(negedge clk_sys);
		{cmd_valid, cmd_write, cmd_addr, cmd_wdata} = {1'b1, w, a, d};
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 20) begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 20) begin
			errors++;
			$display("Error at %0t: no response", $time);
			close_out();
		end
		rdat = rsp_data;
		refd = rsp_refused;
	endtask

	task wait_ready;
		int n;
		n = 0;
		rdat = 32'h0;
		while (rdat[0] !== 1'b1 && n < 10) begin
			cmd(1'b0, `PSW_OFF_PMC, 32'h0);
			n++;
		end
		check({29'h0, rdat[13:12], rdat[0]}, 32'h1);
		if (rdat[0] !== 1'b1)
			close_out();
	endtask

	task t_reset;
		cmd(1'b0, `PSW_OFF_PMC, 32'h0);
		check({29'h0, rdat[13:12], rdat[0]}, 32'h1);
		cmd(1'b0, `PSW_OFF_BYTE_TEST, 32'h0);
		check(rdat, `PSW_BYTE_TEST_VAL);
		cmd(1'b1, `PSW_OFF_PMC, 32'h0000_2000);
		check({30'h0, refd, power_state[1]}, 32'h2);
		$display("test reset done");
	endtask

	task t_d1;
		cmd(1'b1, `PSW_OFF_IRQ_ENABLE, 32'h1);
		cmd(1'b1, `PSW_OFF_PMC, 32'h0000_1100);
		cyc(2);
		check({29'h0, power_state, host_clk_en}, 32'h2);
		cmd(1'b0, `PSW_OFF_PMC, 32'h0);
		check({29'h0, rdat[13:12], rdat[0]}, 32'h2);
		cmd(1'b0, `PSW_OFF_IRQ_STATUS, 32'h0);
		check({31'h0, refd}, 32'h1);
		@(negedge clk_sys) wake_frame_seen = 1'b1;
		@(negedge clk_sys) wake_frame_seen = 1'b0;
		cyc(4);
		check({30'h0, host_irq, wake_seen}, 32'h2);
		cmd(1'b0, `PSW_OFF_PMC, 32'h0);
		check({30'h0, rdat[5:4]}, 32'h2);
		cmd(1'b1, `PSW_OFF_BYTE_TEST, 32'h0);
		wait_ready();
		// drop the frame enable so the wake signal rises again with pin on
		cmd(1'b1, `PSW_OFF_PMC, 32'h0000_0002);
		cmd(1'b1, `PSW_OFF_PMC, 32'h0000_0102);
		cyc(PC + 12);
		check({31'h0, wake_seen}, 32'h1);
		cmd(1'b1, `PSW_OFF_IRQ_STATUS, 32'h1);
		cmd(1'b0, `PSW_OFF_IRQ_STATUS, 32'h0);
		check({31'h0, rdat[0]}, 32'h1);
		cmd(1'b1, `PSW_OFF_PMC, 32'h0000_0100);
		cyc(2);
		check({31'h0, wake_seen}, 32'h0);
		cmd(1'b1, `PSW_OFF_PMC, 32'h0000_0130);
		cmd(1'b1, `PSW_OFF_IRQ_STATUS, 32'h1);
		cmd(1'b0, `PSW_OFF_IRQ_STATUS, 32'h0);
		check({31'h0, rdat[0]}, 32'h0);
		$display("test d1 done");
	endtask

	task t_d2;
		cmd(1'b1, `PSW_OFF_PHY_MODE, 32'h0000_2000);
		@(negedge clk_sys) line_energy_raw = 1'b1;
		cyc(8);
		cmd(1'b1, `PSW_OFF_PMC, 32'h0000_220a);
		cnt = 32'h0;
		repeat (PC + 40) begin
			@(negedge clk_sys);
			if (wake_seen === 1'b1)
				cnt++;
		end
		check(cnt, PC);
		check({28'h0, power_state, int_clk_en, mac_pm_clk_en}, 32'h8);
		cmd(1'b0, `PSW_OFF_PMC, 32'h0);
		check({30'h0, rdat[5:4]}, 32'h1);
		cmd(1'b1, `PSW_OFF_BYTE_TEST, 32'h0);
		wait_ready();
		cmd(1'b1, `PSW_OFF_PMC, 32'h0000_0030);
		check({31'h0, refd}, 32'h1);
		cmd(1'b1, `PSW_OFF_PHY_MODE, 32'h0);
		cmd(1'b0, `PSW_OFF_PHY_IRQ_FLAG, 32'h0);
		check({31'h0, rdat[1]}, 32'h1);
		cmd(1'b1, `PSW_OFF_PMC, 32'h0000_0030);
		check({31'h0, refd}, 32'h0);
		cmd(1'b0, `PSW_OFF_PMC, 32'h0);
		check({30'h0, rdat[5:4]}, 32'h0);
		line_energy_raw = 1'b0;
		$display("test d2 done");
	endtask

	task t_phy;
		cmd(1'b1, `PSW_OFF_PHY_CTRL, 32'h0000_0800);
		cyc(2);
		check({29'h0, srst_seen, phy_power_down, phy_active}, 32'h2);
		cmd(1'b1, `PSW_OFF_PHY_CTRL, 32'h0);
		cyc(2);
		check({30'h0, srst_seen, phy_power_down}, 32'h2);
		cmd(1'b1, `PSW_OFF_PHY_MODE, 32'h0000_2000);
		cyc(2);
		check({31'h0, phy_active}, 32'h0);
		@(negedge clk_sys) line_energy_raw = 1'b1;
		cyc(8);
		check({31'h0, phy_active}, 32'h1);
		$display("test phy done");
	endtask

	initial begin
		cyc(12);
		resetn = 1'b1;
		t_reset();
		t_d1();
		t_d2();
		t_phy();
		close_out();
	end
endmodule
